// >>> common/scp_cfg.svh
// Constants for the serial configuration command port
`ifndef SCP_CFG_SVH
`define SCP_CFG_SVH
`define SCP_CLK_HZ 100000000
`define SCP_BAUD 9600
`define SCP_BIT_CLKS ((`SCP_CLK_HZ + `SCP_BAUD - 1) / `SCP_BAUD)
`define SCP_GAP_MS 50
`define SCP_GAP_CLKS (`SCP_CLK_HZ / 1000 * `SCP_GAP_MS)
`define SCP_TG_BYTES 14
`define SCP_SYNC1 8'hA5
`define SCP_SYNC0 8'h5A
`define SCP_HDR_DEV 8'h8B
`define SCP_HDR_HOST 8'hAB
`define SCP_TYPE_THR_WR 8'h02
`define SCP_TYPE_CFG_RD 8'h40
`define SCP_TYPE_IDENT 8'h00
`define SCP_TYPE_VER 8'h8C
`define SCP_TYPE_THR_RPT 8'h01
`define SCP_TYPE_ACK 8'h58
`define SCP_TYPE_FAIL 8'h19
`define SCP_THR0_RST 8'h06
`define SCP_THR1_RST 8'h05
`define SCP_THR2_RST 8'h0E
// Arbitrary identity and version reset values
`define SCP_VER_RST 32'h01020304
`define SCP_IDENT_RST 24'h000000
`define SCP_MODID_RST 32'h00000001
`define SCP_REG_STATUS 8'h00
`define SCP_REG_THRESH 8'h04
`define SCP_REG_VERSION 8'h08
`define SCP_REG_IDENT 8'h0C
`define SCP_REG_MODID 8'h10
`endif

// >>> common/scp_pkg.sv
// Types shared by the serial configuration command port
package scp_pkg;
  typedef struct packed {
    logic [7:0] thr2;
    logic [7:0] thr1;
    logic [7:0] thr0;
  } scp_thresh_t;
  typedef struct packed {
    logic [7:0] tg_type;
    logic [0:8][7:0] data;
  } scp_telegram_t;
  typedef enum logic [2:0] {RP_ACK, RP_FAIL, RP_VER, RP_IDENT, RP_THR} scp_reply_t;
endpackage

// >>> hdl/scp_uart_rx.sv
// Byte receiver: 8N1, least significant bit first
`timescale 1ns/10ps
module scp_uart_rx #(
  parameter int unsigned BIT_CLKS = 10417
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_line,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  localparam int CW = $clog2(BIT_CLKS + 1);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} scp_rx_state_t;
  scp_rx_state_t state_reg;
  logic [CW-1:0] cnt_reg;
  logic [2:0] bit_reg;
  always_ff @(posedge aclk) begin
    byte_valid <= 1'b0;
    if (!aresetn) begin
      state_reg <= RX_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      byte_data <= 8'h00;
    end else begin
      unique case (state_reg)
        RX_IDLE: begin
          cnt_reg <= '0;
          if (!rx_line) state_reg <= RX_START;
        end
        RX_START: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Mid start bit: a glitch shorter than half a bit is dropped
          if (cnt_reg == CW'(BIT_CLKS / 2)) begin
            cnt_reg <= '0;
            bit_reg <= '0;
            state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CW'(BIT_CLKS - 1)) begin
            cnt_reg <= '0;
            byte_data <= {rx_line, byte_data[7:1]};
            bit_reg <= bit_reg + 1'b1;
            if (bit_reg == 3'h7) state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CW'(BIT_CLKS - 1)) begin
            // Framing error drops the byte silently
            byte_valid <= rx_line;
            state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end
endmodule // scp_uart_rx

// >>> hdl/scp_uart_tx.sv
// Byte transmitter: 8N1, least significant bit first
`timescale 1ns/10ps
module scp_uart_tx #(
  parameter int unsigned BIT_CLKS = 10417
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [7:0] din,
  output logic ready,
  output logic tx_line
);
  localparam int CW = $clog2(BIT_CLKS + 1);
  logic [9:0] shift_reg;
  logic [3:0] left_reg;
  logic [CW-1:0] cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_reg <= 10'h3FF;
      left_reg <= 4'h0;
      cnt_reg <= '0;
      tx_line <= 1'b1;
      ready <= 1'b1;
    end else if (ready) begin
      tx_line <= 1'b1;
      if (start) begin
        shift_reg <= {1'b1, din, 1'b0};
        left_reg <= 4'hA;
        cnt_reg <= '0;
        ready <= 1'b0;
      end
    end else begin
      tx_line <= shift_reg[0];
      cnt_reg <= cnt_reg + 1'b1;
      if (cnt_reg == CW'(BIT_CLKS - 1)) begin
        cnt_reg <= '0;
        shift_reg <= {1'b1, shift_reg[9:1]};
        left_reg <= left_reg - 1'b1;
        if (left_reg == 4'h1) ready <= 1'b1;
      end
    end
  end
  idle_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ready && !$past(start) |=> tx_line) else $error("line not idle high");
  start_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ready && start |=> ##1 !tx_line) else $error("no start bit");
endmodule // scp_uart_tx

// >>> hdl/scp_top.sv
// Serial configuration command port with AXI4-Lite register access
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`include "scp_cfg.svh"
module scp_top #(
  parameter int unsigned BIT_CLKS = `SCP_BIT_CLKS,
  parameter int unsigned GAP_CLKS = `SCP_GAP_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic indicator_pin,
  input wire logic wake_event,
  input wire logic timer_event,
  input wire logic config_rx_line,
  output logic config_tx_line,
  output logic serial_mode,
  output logic wake_accept,
  output scp_pkg::scp_thresh_t thresholds
);
  import scp_pkg::*;
  localparam int GW = $clog2(GAP_CLKS + 1);

  logic rx_valid;
  logic [7:0] rx_data;
  logic tx_ready;
  logic tx_start_reg;
  logic [7:0] tx_byte_reg;
  logic any_wake;
  assign any_wake = wake_event | timer_event;

  scp_uart_rx #(.BIT_CLKS(BIT_CLKS)) u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_line(config_rx_line),
    .byte_valid(rx_valid),
    .byte_data(rx_data)
  );
  scp_uart_tx #(.BIT_CLKS(BIT_CLKS)) u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tx_start_reg),
    .din(tx_byte_reg),
    .ready(tx_ready),
    .tx_line(config_tx_line)
  );

  // Mode control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_mode <= 1'b0;
      wake_accept <= 1'b0;
    end else begin
      wake_accept <= any_wake && !serial_mode && !indicator_pin;
      if (!serial_mode && any_wake && indicator_pin) serial_mode <= 1'b1;
      else if (serial_mode && !indicator_pin) serial_mode <= 1'b0;
    end
  end

  // Command assembly
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_buf [0:10];
  logic [7:0] rx_sum_reg;
  logic [GW-1:0] gap_reg;
  logic cmd_done_reg;
  logic cmd_ok_reg;
  logic timeout_reg;
  always_ff @(posedge aclk) begin
    cmd_done_reg <= 1'b0;
    timeout_reg <= 1'b0;
    if (!aresetn) begin
      rx_idx_reg <= 4'h0;
      rx_sum_reg <= 8'h00;
      gap_reg <= '0;
      cmd_ok_reg <= 1'b0;
      for (int i = 0; i < 11; i++) rx_buf[i] <= 8'h00;
    end else if (!serial_mode) begin
      rx_idx_reg <= 4'h0;
      gap_reg <= '0;
    end else if (rx_valid) begin
      gap_reg <= '0;
      rx_idx_reg <= rx_idx_reg + 1'b1;
      if (rx_idx_reg == 4'h0) begin
        if (rx_data != `SCP_SYNC1) rx_idx_reg <= 4'h0;
        rx_sum_reg <= 8'h00;
      end else if (rx_idx_reg == 4'h1) begin
        // A repeated first sync byte keeps the hunt alive
        if (rx_data != `SCP_SYNC0) rx_idx_reg <= (rx_data == `SCP_SYNC1) ? 4'h1 : 4'h0;
      end else if (rx_idx_reg == 4'(`SCP_TG_BYTES - 1)) begin
        rx_idx_reg <= 4'h0;
        cmd_done_reg <= 1'b1;
        cmd_ok_reg <= (rx_data == rx_sum_reg) && (rx_buf[0] == `SCP_HDR_HOST);
      end else begin
        rx_buf[rx_idx_reg - 4'h2] <= rx_data;
        rx_sum_reg <= rx_sum_reg + rx_data;
      end
    end else if (rx_idx_reg != 4'h0) begin
      gap_reg <= gap_reg + 1'b1;
      if (gap_reg == GW'(GAP_CLKS - 1)) begin
        rx_idx_reg <= 4'h0;
        gap_reg <= '0;
        timeout_reg <= 1'b1;
      end
    end
  end

  // Command execution
  logic reply_pend_reg;
  scp_reply_t reply_kind_reg;
  logic tx_active_reg;
  logic [7:0] good_cnt_reg;
  logic [7:0] bad_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresholds <= {`SCP_THR2_RST, `SCP_THR1_RST, `SCP_THR0_RST};
      reply_pend_reg <= 1'b0;
      reply_kind_reg <= RP_ACK;
      good_cnt_reg <= 8'h00;
      bad_cnt_reg <= 8'h00;
    end else begin
      if (tx_active_reg) reply_pend_reg <= 1'b0;
      if (timeout_reg) bad_cnt_reg <= bad_cnt_reg + 1'b1;
      // Commands that arrive while a reply is still going out are dropped
      if (cmd_done_reg && !reply_pend_reg && !tx_active_reg) begin
        reply_pend_reg <= 1'b1;
        if (cmd_ok_reg && rx_buf[1] == `SCP_TYPE_THR_WR) begin
          thresholds <= {rx_buf[2], rx_buf[3], rx_buf[4]};
          reply_kind_reg <= RP_ACK;
          good_cnt_reg <= good_cnt_reg + 1'b1;
        end else if (cmd_ok_reg && rx_buf[1] == `SCP_TYPE_CFG_RD) begin
          reply_kind_reg <= RP_VER;
          good_cnt_reg <= good_cnt_reg + 1'b1;
        end else begin
          reply_kind_reg <= RP_FAIL;
          bad_cnt_reg <= bad_cnt_reg + 1'b1;
        end
      end
    end
  end

  // Reply transmission
  logic [31:0] version_reg;
  logic [23:0] ident_reg;
  logic [31:0] modid_reg;
  scp_reply_t tx_kind_reg;
  logic [3:0] tx_idx_reg;
  logic [7:0] tx_sum_reg;
  scp_telegram_t tg;
  logic [7:0] tx_byte;
  always_comb begin
    tg = '0;
    unique case (tx_kind_reg)
      RP_ACK: tg.tg_type = `SCP_TYPE_ACK;
      RP_FAIL: tg.tg_type = `SCP_TYPE_FAIL;
      RP_VER: begin
        tg.tg_type = `SCP_TYPE_VER;
        tg.data[0:3] = version_reg;
      end
      RP_IDENT: begin
        tg.tg_type = `SCP_TYPE_IDENT;
        tg.data[0:2] = ident_reg;
        tg.data[4:7] = modid_reg;
      end
      RP_THR: begin
        tg.tg_type = `SCP_TYPE_THR_RPT;
        tg.data[0:2] = thresholds;
      end
    endcase
  end
  always_comb begin
    if (tx_idx_reg == 4'h0) tx_byte = `SCP_SYNC1;
    else if (tx_idx_reg == 4'h1) tx_byte = `SCP_SYNC0;
    else if (tx_idx_reg == 4'h2) tx_byte = `SCP_HDR_DEV;
    else if (tx_idx_reg == 4'h3) tx_byte = tg.tg_type;
    else if (tx_idx_reg == 4'(`SCP_TG_BYTES - 1)) tx_byte = tx_sum_reg;
    else tx_byte = tg.data[tx_idx_reg - 4'h4];
  end
  always_ff @(posedge aclk) begin
    tx_start_reg <= 1'b0;
    if (!aresetn) begin
      tx_active_reg <= 1'b0;
      tx_kind_reg <= RP_ACK;
      tx_idx_reg <= 4'h0;
      tx_sum_reg <= 8'h00;
      tx_byte_reg <= 8'h00;
    end else if (!tx_active_reg) begin
      if (reply_pend_reg) begin
        tx_active_reg <= 1'b1;
        tx_kind_reg <= reply_kind_reg;
        tx_idx_reg <= 4'h0;
        tx_sum_reg <= 8'h00;
      end
    end else if (tx_ready && !tx_start_reg) begin
      // Guard on the start pulse: ready drops only one cycle later
      tx_start_reg <= 1'b1;
      tx_byte_reg <= tx_byte;
      tx_idx_reg <= tx_idx_reg + 1'b1;
      if (tx_idx_reg >= 4'h2) tx_sum_reg <= tx_sum_reg + tx_byte;
      if (tx_idx_reg == 4'(`SCP_TG_BYTES - 1)) begin
        tx_idx_reg <= 4'h0;
        tx_sum_reg <= 8'h00;
        if (tx_kind_reg == RP_VER) tx_kind_reg <= RP_IDENT;
        else if (tx_kind_reg == RP_IDENT) tx_kind_reg <= RP_THR;
        else tx_active_reg <= 1'b0;
      end
    end
  end

  // AXI4-Lite write side
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (st[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction
  // Readies are flops of their own, always the inverse of the full flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      version_reg <= `SCP_VER_RST;
      ident_reg <= `SCP_IDENT_RST;
      modid_reg <= `SCP_MODID_RST;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        unique case (aw_addr_reg)
          `SCP_REG_VERSION: version_reg <= merge(version_reg, w_data_reg, w_strb_reg);
          `SCP_REG_IDENT: ident_reg <= 24'(merge({8'h00, ident_reg}, w_data_reg, w_strb_reg));
          `SCP_REG_MODID: modid_reg <= merge(modid_reg, w_data_reg, w_strb_reg);
          `SCP_REG_STATUS, `SCP_REG_THRESH: ;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rresp <= 2'h0;
      unique case (s_axi_araddr)
        `SCP_REG_STATUS: s_axi_rdata <= {8'h00, bad_cnt_reg, good_cnt_reg, 6'h00, tx_active_reg, serial_mode};
        `SCP_REG_THRESH: s_axi_rdata <= {8'h00, thresholds};
        `SCP_REG_VERSION: s_axi_rdata <= version_reg;
        `SCP_REG_IDENT: s_axi_rdata <= {8'h00, ident_reg};
        `SCP_REG_MODID: s_axi_rdata <= modid_reg;
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end

  enter_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !serial_mode && any_wake && indicator_pin |=> serial_mode) else $error("serial mode not entered");
  wake_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_mode && any_wake |=> !wake_accept) else $error("wake accepted in serial mode");
  leave_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_mode && !indicator_pin |=> !serial_mode) else $error("serial mode not left");
  reset_thresh_a: assert property (@(posedge aclk)
    !aresetn |=> thresholds == 24'h0E0506) else $error("bad default thresholds");
  gap_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timeout_reg |-> rx_idx_reg == 4'h0 && !cmd_done_reg) else $error("timeout kept command");
  sync_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start_reg && $past(tx_idx_reg) == 4'h0 |-> tx_byte_reg == 8'hA5) else $error("bad first sync");
  header_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start_reg && $past(tx_idx_reg) == 4'h2 |-> tx_byte_reg == 8'h8B) else $error("bad header");
  write_ack_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_done_reg && !reply_pend_reg && !tx_active_reg && rx_buf[1] == `SCP_TYPE_THR_WR |=> reply_pend_reg
      && (reply_kind_reg == RP_ACK || reply_kind_reg == RP_FAIL) && ((reply_kind_reg == RP_ACK) == $past(cmd_ok_reg)))
    else $error("no reply queued");
  read_chain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_start_reg && $past(tx_idx_reg) == 4'hD && $past(tx_kind_reg) == RP_VER |-> tx_kind_reg == RP_IDENT)
    else $error("identity report did not follow version");
endmodule // scp_top

// >>> bench/scp_host_model.sv
// Configuration host model: frames commands and collects reply bytes
`timescale 1ns/10ps
module scp_host_model #(
  parameter int unsigned BIT_CLKS = 16
) (
  input wire logic aclk,
  input wire logic tx_line,
  output logic rx_line
);
  import scp_pkg::*;
  logic [7:0] rx_q[$];
  initial rx_line = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      rx_line <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i - 1]);
      repeat (BIT_CLKS) @(posedge aclk);
    end
  endtask
  // Bytes go back to back; nb below 14 cuts a frame short on purpose
  task automatic send_tg(input logic [7:0] hdr, input scp_telegram_t tg, input logic [7:0] bad, input int nb);
    logic [0:13][7:0] fr;
    logic [7:0] sum;
    sum = hdr + tg.tg_type;
    for (int i = 0; i < 9; i++) sum = sum + tg.data[i];
    fr = {8'hA5, 8'h5A, hdr, tg.tg_type, tg.data, sum ^ bad};
    for (int i = 0; i < nb; i++) send_byte(fr[i]);
  endtask
  // Mid-bit sampling; a low stop bit poisons the byte so the compare fails
  initial begin : rx_proc
    logic [7:0] b;
    forever begin
      @(negedge tx_line);
      repeat (BIT_CLKS / 2) @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge aclk);
        b[i] = tx_line;
      end
      repeat (BIT_CLKS) @(posedge aclk);
      if (tx_line !== 1'b1) b = 'x;
      rx_q.push_back(b);
    end
  end
endmodule // scp_host_model

// >>> bench/testbench.sv
// Self-checking bench for the serial configuration command port
`timescale 1ns/10ps
module testbench;
  import scp_pkg::*;
  localparam int unsigned BITC = 16;
  localparam int unsigned GAPC = 2000;
  localparam int LIMIT = 90000;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, indicator_pin, wake_event, timer_event;
  logic config_rx_line, config_tx_line, serial_mode, wake_accept;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  scp_thresh_t thresholds;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [31:0] seed = 32'hE9AA381F;
  logic [31:0] ver, ident, modid;
  logic [23:0] thr_exp = 24'h0E0506;
  scp_top #(.BIT_CLKS(BITC), .GAP_CLKS(GAPC)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .indicator_pin, .wake_event, .timer_event, .config_rx_line, .config_tx_line, .serial_mode,
    .wake_accept, .thresholds);
  scp_host_model #(.BIT_CLKS(BITC)) host_u (.aclk(aclk), .tx_line(config_tx_line), .rx_line(config_rx_line));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] cks(input scp_telegram_t t);
    cks = 8'h8B + t.tg_type;
    for (int i = 0; i < 9; i++) cks = cks + t.data[i];
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic awp, wp;
    awp = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (awp || wp) begin
      @(posedge aclk);
      if (awp && s_axi_awready === 1'b1) begin
        awp = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wp && s_axi_wready === 1'b1) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic expect_tg(input scp_telegram_t t);
    logic [0:13][7:0] fr;
    fr = {8'hA5, 8'h5A, 8'h8B, t.tg_type, t.data, cks(t)};
    for (int k = 0; k < 6000 && host_u.rx_q.size() < 14; k++) @(posedge aclk);
    chk("reply length", 14, host_u.rx_q.size());
    for (int i = 0; i < 14 && host_u.rx_q.size() > 0; i++) chk("reply byte", fr[i], host_u.rx_q.pop_front());
  endtask
  task automatic wake_try(input logic w, input logic tm, output int n);
    @(posedge aclk);
    wake_event <= w;
    timer_event <= tm;
    @(posedge aclk);
    wake_event <= 1'b0;
    timer_event <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge aclk);
      n += (wake_accept !== 1'b0);
    end
  endtask
  task automatic cfg_read();
    host_u.send_tg(8'hAB, '{8'h40, 72'({rnd(), rnd(), rnd()})}, 8'h00, 14);
    expect_tg('{8'h8C, {ver, 40'h0}});
    expect_tg('{8'h00, {ident[23:0], 8'h00, modid, 8'h00}});
    expect_tg('{8'h01, {thr_exp, 48'h0}});
  endtask
  initial begin : main
    scp_telegram_t tg;
    logic [31:0] rd, st0;
    logic [0:2][7:0] fl [3];
    int n;
    fl = '{'{8'hAB, 8'h02, 8'h01}, '{8'h8B, 8'h02, 8'h00}, '{8'hAB, 8'h33, 8'h00}};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {indicator_pin, wake_event, timer_event, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    chk("thresholds", {8'h00, thr_exp}, {8'h00, thresholds});
    chk("tx idle", 1, config_tx_line);
    wake_try(1'b1, 1'b0, n);
    chk("wake outside", 1, n);
    @(posedge aclk);
    indicator_pin <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("mode without wake", 0, serial_mode);
    wake_try(1'b0, 1'b1, n);
    chk("mode entered", 1, serial_mode);
    wake_try(1'b1, 1'b0, n);
    chk("wake in mode", 0, n);
    wake_try(1'b0, 1'b1, n);
    chk("timer in mode", 0, n);
    ver = rnd();
    ident = rnd() >> 8;
    modid = rnd();
    axi_wr(8'h08, ver, 2'b00);
    axi_wr(8'h0C, ident, 2'b00);
    axi_wr(8'h10, modid, 2'b00);
    s_axi_wstrb <= 4'h3;
    rd = rnd();
    axi_wr(8'h10, rd, 2'b00);
    modid[15:0] = rd[15:0];
    s_axi_wstrb <= 4'hF;
    axi_rd(8'h10, rd, 2'b00);
    chk("module id reg", modid, rd);
    axi_wr(8'h04, rnd(), 2'b00);
    axi_wr(8'h40, rnd(), 2'b10);
    axi_rd(8'h40, rd, 2'b10);
    chk("unmapped read", 0, rd);
    axi_rd(8'h08, rd, 2'b00);
    chk("version reg", ver, rd);
    cfg_read();
    for (int j = 0; j < 3; j++) begin
      tg.tg_type = 8'h02;
      tg.data = (j == 0) ? {8'h00, 8'hFF, 8'h80, 48'h0} : 72'({rnd(), rnd(), rnd()});
      host_u.send_tg(8'hAB, tg, 8'h00, 14);
      thr_exp = {tg.data[0], tg.data[1], tg.data[2]};
      expect_tg('{8'h58, 72'h0});
      chk("thresholds", {8'h00, thr_exp}, {8'h00, thresholds});
    end
    axi_rd(8'h04, rd, 2'b00);
    chk("threshold reg", {8'h00, thr_exp}, rd);
    for (int j = 0; j < 3; j++) begin
      host_u.send_tg(fl[j][0], '{fl[j][1], 72'({rnd(), rnd(), rnd()})}, fl[j][2], 14);
      expect_tg('{8'h19, 72'h0});
      chk("thresholds kept", {8'h00, thr_exp}, {8'h00, thresholds});
    end
    cfg_read();
    axi_rd(8'h00, st0, 2'b00);
    host_u.send_tg(8'hAB, '{8'h02, 72'h0}, 8'h00, 5);
    repeat (GAPC + 200) @(posedge aclk);
    axi_rd(8'h00, rd, 2'b00);
    chk("abandoned count", 32'(st0[23:16] + 8'h01), 32'(rd[23:16]));
    chk("no reply", 0, host_u.rx_q.size());
    host_u.send_tg(8'hAB, '{8'h02, {thr_exp, 48'h0}}, 8'h00, 14);
    expect_tg('{8'h58, 72'h0});
    @(posedge aclk);
    indicator_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("mode left", 0, serial_mode);
    wake_try(1'b1, 1'b0, n);
    chk("wake after leave", 1, n);
    end_sim();
  end
endmodule // testbench
